// ### logic/led_pwm_map.svh
// Behaviour
// - Blink period from code, 256 linear steps.
// - Blink frequency is 24 over code plus one.
// - Blink period write staged until update write.
// - Blink on-fraction is duty code over 256.
// - Blink duty write staged until update write.
// - Zero to 36h activates staged scaling values.
// - Zero to 37h activates PWM and blink values.
// - 0xAE to 3Fh restores every register default.
// - Power-up defaults leave outputs in shutdown.
// - Range bit D5 cuts full-scale current eightfold.
// - Each output scaled by its 8-bit value.
// - Each output PWM on-fraction is N over 256.
// - PWM runs at 200Hz or 25kHz, selectable.
// - All channels start their on-phase together.
// - Open status refreshes from enable rise until clear.
// - Report enable drives interrupt low on opens.
// - Blink select bit gates output with blink wave.
// - DC bit forces channel fully on while its blink select bit is clear.
`ifndef LED_PWM_MAP_SVH
`define LED_PWM_MAP_SVH

// ****************************************
// Timing
// ****************************************
`define CLK_HZ 20000000
`define CLK_PERIOD_NS 50
`define PWM_STEPS 256
`define PWM_SLOW_HZ 200
`define PWM_FAST_HZ 25000
`define BLINK_BASE_HZ 24
`define PWM_SLOW_DIV (`CLK_HZ / (`PWM_SLOW_HZ * `PWM_STEPS))
`define PWM_FAST_DIV (`CLK_HZ / (`PWM_FAST_HZ * `PWM_STEPS))
`define BLINK_TICK_DIV (`CLK_HZ / (`BLINK_BASE_HZ * `PWM_STEPS))

// ****************************************
// Register offsets
// ****************************************
`define A_CTRL 8'h00
`define A_GCC 8'h01
`define A_SCALE_FIRST 8'h02
`define A_ODET 8'h14
`define A_DC_FIRST 8'h1A
`define A_PWM_FIRST 8'h1F
`define A_BSEL_FIRST 8'h31
`define A_BPER 8'h34
`define A_BDUTY 8'h35
`define A_SCALE_UPD 8'h36
`define A_UPD 8'h37
`define A_SRST 8'h3F
`define A_OPEN_FIRST 8'h95

// ****************************************
// Fields, keys and reset values
// ****************************************
`define CTRL_RUN_BIT 0
`define CTRL_FSEL_BIT 1
`define CTRL_RANGE_BIT 5
`define ODET_EN_BIT 0
`define ODET_REPORT_BIT 1
`define UPD_KEY 8'h00
`define SRST_KEY 8'hAE
`define REG_RESET 8'h00

`endif

// ### logic/led_pwm_pkg.sv
package led_pwm_pkg;

  // Open-detect sequencing, one-hot
  typedef enum logic [1:0] {
    OD_IDLE = 2'b01,
    OD_ACTIVE = 2'b10
  } od_state_t;

endpackage : led_pwm_pkg

// ### logic/channel_gate.sv
`timescale 1ns/10ps
// One sink channel: compares the shared phase against its duty and
// applies the DC, blink and run gating.
module channel_gate #(
  parameter int W = 8
) (
  // Clock and clear
  input wire logic clock,
  input wire logic clear,
  // Shared timebase
  input wire logic [W-1:0] phase,
  input wire logic blink_on,
  input wire logic run,
  // Channel settings
  input wire logic [W-1:0] duty,
  input wire logic dc,
  input wire logic blink_sel,
  // Sink drive
  output logic on_r
);

  logic pwm_on; // Raw PWM comparison

  // Value N is on for N of the 2^W phases
  assign pwm_on = dc | (phase < duty);

  // ****************************************
  // Registered sink drive
  // ****************************************
  always_ff @(posedge clock) begin
    if (clear) begin
      on_r <= 1'b0;
    end else begin
      // Blink window gates the PWM, plain mode otherwise
      on_r <= run & pwm_on & (~blink_sel | blink_on);
    end
  end

endmodule : channel_gate

// ### logic/led_pwm_blink_update_control.sv
`timescale 1ns/10ps
`include "led_pwm_map.svh"
// 18-channel PWM, scaling, blink and open-detect register core.
module led_pwm_blink_update_control #(
  parameter int CH = 18,
  parameter int PWM_SLOW_DIV = `PWM_SLOW_DIV,
  parameter int PWM_FAST_DIV = `PWM_FAST_DIV,
  parameter int BLINK_TICK_DIV = `BLINK_TICK_DIV
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Host register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Open-LED sense from the sinks
  input wire logic [CH-1:0] open_sense,
  // Sink control
  output logic [CH-1:0] led_sink_channel,
  output logic [CH*8-1:0] active_scale_flat,
  output logic [7:0] global_current_code,
  output logic current_range_eighth,
  // Fault report
  output logic fault_irq_n
);

  // ****************************************
  // Declarations
  // ****************************************
  logic clear; // Power-up or soft reset
  logic srst; // Soft reset command seen
  logic upd_main; // PWM and blink update command
  logic upd_scale; // Scaling update command
  logic [7:0] ctrl_r; // Control register
  logic [7:0] gcc_r; // Global current code
  logic [7:0] odet_r; // Open-detect control
  logic [7:0] scale_stage_r [CH]; // Staged scaling
  logic [7:0] scale_act_r [CH]; // Active scaling
  logic [7:0] pwm_stage_r [CH]; // Staged PWM duty
  logic [7:0] pwm_act_r [CH]; // Active PWM duty
  logic [CH-1:0] dc_r; // DC output bits
  logic [CH-1:0] bsel_stage_r; // Staged blink select
  logic [CH-1:0] bsel_act_r; // Active blink select
  logic [7:0] bper_stage_r; // Staged blink period code
  logic [7:0] bper_act_r; // Active blink period code
  logic [7:0] bduty_stage_r; // Staged blink duty code
  logic [7:0] bduty_act_r; // Active blink duty code
  logic [8:0] pwm_pre_r; // PWM step prescaler
  logic [8:0] pwm_pre_end; // Prescaler terminal count
  logic [7:0] pwm_phase_r; // Shared PWM phase
  logic [11:0] blink_tick_r; // Blink base tick counter
  logic [7:0] blink_step_r; // Divide by period code plus one
  logic [7:0] blink_phase_r; // Blink phase, 256 steps
  logic blink_on_r; // Blink on window
  led_pwm_pkg::od_state_t od_state_r; // Open-detect state
  logic od_en_d_r; // Delayed open-detect enable
  logic [CH-1:0] open_r; // Open-LED status

  // Combined synchronous clear
  assign srst = reg_wr && (reg_addr == `A_SRST) && (reg_wdata == `SRST_KEY);
  assign clear = ~rstn | srst;
  assign upd_main = reg_wr && (reg_addr == `A_UPD) && (reg_wdata == `UPD_KEY);
  assign upd_scale = reg_wr && (reg_addr == `A_SCALE_UPD)
                     && (reg_wdata == `UPD_KEY);

  // ****************************************
  // Control, global current, open-detect control
  // ****************************************
  always_ff @(posedge clock) begin
    if (clear) begin
      // Run bit clear after reset: software shutdown
      ctrl_r <= `REG_RESET;
      gcc_r <= `REG_RESET;
      odet_r <= `REG_RESET;
    end else if (reg_wr) begin
      if (reg_addr == `A_CTRL) begin
        ctrl_r <= reg_wdata;
      end
      if (reg_addr == `A_GCC) begin
        gcc_r <= reg_wdata;
      end
      if (reg_addr == `A_ODET) begin
        odet_r <= reg_wdata;
      end
    end
  end

  // ****************************************
  // Scaling: staged, then activated together
  // ****************************************
  always_ff @(posedge clock) begin
    if (clear) begin
      for (int i = 0; i < CH; i++) begin
        scale_stage_r[i] <= `REG_RESET;
        scale_act_r[i] <= `REG_RESET;
      end
    end else begin
      for (int i = 0; i < CH; i++) begin
        if (reg_wr && (reg_addr == `A_SCALE_FIRST + 8'(i))) begin
          scale_stage_r[i] <= reg_wdata;
        end
      end
      // All channels copy in one cycle
      if (upd_scale) begin
        scale_act_r <= scale_stage_r;
      end
    end
  end

  // ****************************************
  // PWM duty, blink select, blink period and duty
  // ****************************************
  always_ff @(posedge clock) begin
    if (clear) begin
      for (int i = 0; i < CH; i++) begin
        pwm_stage_r[i] <= `REG_RESET;
        pwm_act_r[i] <= `REG_RESET;
      end
      bsel_stage_r <= '0;
      bsel_act_r <= '0;
      bper_stage_r <= `REG_RESET;
      bper_act_r <= `REG_RESET;
      bduty_stage_r <= `REG_RESET;
      bduty_act_r <= `REG_RESET;
    end else begin
      for (int i = 0; i < CH; i++) begin
        if (reg_wr && (reg_addr == `A_PWM_FIRST + 8'(i))) begin
          pwm_stage_r[i] <= reg_wdata;
        end
        // Six channels per byte, in D2:D0 then D6:D4
        if (reg_wr && (reg_addr == `A_BSEL_FIRST + 8'(i / 6))) begin
          bsel_stage_r[i] <= reg_wdata[(i % 6) + ((i % 6) / 3)];
        end
      end
      if (reg_wr && (reg_addr == `A_BPER)) begin
        bper_stage_r <= reg_wdata;
      end
      if (reg_wr && (reg_addr == `A_BDUTY)) begin
        bduty_stage_r <= reg_wdata;
      end
      // One write moves every staged PWM and blink value at once; scaling waits for 36h
      if (upd_main) begin
        pwm_act_r <= pwm_stage_r;
        bsel_act_r <= bsel_stage_r;
        bper_act_r <= bper_stage_r;
        bduty_act_r <= bduty_stage_r;
      end
    end
  end

  // ****************************************
  // DC output bits, applied at once
  // ****************************************
  always_ff @(posedge clock) begin
    if (clear) begin
      dc_r <= '0;
    end else begin
      for (int i = 0; i < CH; i++) begin
        if (reg_wr && (reg_addr == `A_DC_FIRST + 8'(i / 6))) begin
          dc_r[i] <= reg_wdata[(i % 6) + ((i % 6) / 3)];
        end
      end
    end
  end

  // ****************************************
  // PWM timebase shared by all channels
  // ****************************************
  // Step length picks 200 Hz or 25 kHz over 256 steps
  assign pwm_pre_end = ctrl_r[`CTRL_FSEL_BIT] ? 9'(PWM_FAST_DIV - 1)
                                              : 9'(PWM_SLOW_DIV - 1);

  always_ff @(posedge clock) begin
    if (clear) begin
      pwm_pre_r <= '0;
      pwm_phase_r <= '0;
    end else if (pwm_pre_r >= pwm_pre_end) begin
      // One phase for every channel keeps them aligned
      pwm_pre_r <= '0;
      pwm_phase_r <= pwm_phase_r + 8'h01;
    end else begin
      pwm_pre_r <= pwm_pre_r + 9'h001;
    end
  end

  // ****************************************
  // Group blink generator
  // ****************************************
  // Base tick is 1/(24*256) s; each phase step is code+1 ticks
  always_ff @(posedge clock) begin
    if (clear) begin
      blink_tick_r <= '0;
      blink_step_r <= '0;
      blink_phase_r <= '0;
    end else if (blink_tick_r >= 12'(BLINK_TICK_DIV - 1)) begin
      blink_tick_r <= '0;
      if (blink_step_r >= bper_act_r) begin
        // Period is 256 * (code + 1) base ticks
        blink_step_r <= '0;
        blink_phase_r <= blink_phase_r + 8'h01;
      end else begin
        blink_step_r <= blink_step_r + 8'h01;
      end
    end else begin
      blink_tick_r <= blink_tick_r + 12'h001;
    end
  end

  // On during the first duty/256 of each blink period
  always_ff @(posedge clock) begin
    if (clear) begin
      blink_on_r <= 1'b0;
    end else begin
      blink_on_r <= (blink_phase_r < bduty_act_r);
    end
  end

  // ****************************************
  // Channel gates
  // ****************************************
  for (genvar g = 0; g < CH; g++) begin : gen_ch
    channel_gate #(
      .W(8)
    ) u_gate (
      .clock(clock),
      .clear(clear),
      .phase(pwm_phase_r),
      .blink_on(blink_on_r),
      .run(ctrl_r[`CTRL_RUN_BIT]),
      .duty(pwm_act_r[g]),
      .dc(dc_r[g]),
      .blink_sel(bsel_act_r[g]),
      .on_r(led_sink_channel[g])
    );
    // Per-channel current scale to the sink
    assign active_scale_flat[g*8 +: 8] = scale_act_r[g];
  end

  // Global current and range to the analog sinks
  assign global_current_code = gcc_r;
  assign current_range_eighth = ctrl_r[`CTRL_RANGE_BIT];

  // ****************************************
  // Open detection
  // ****************************************
  always_ff @(posedge clock) begin
    if (clear) begin
      od_state_r <= led_pwm_pkg::OD_IDLE;
      od_en_d_r <= 1'b0;
      open_r <= '0;
    end else begin
      od_en_d_r <= odet_r[`ODET_EN_BIT];
      case (od_state_r)
        led_pwm_pkg::OD_IDLE: begin
          // Starts only on a 0 to 1 change of the enable
          if (odet_r[`ODET_EN_BIT] && !od_en_d_r) begin
            od_state_r <= led_pwm_pkg::OD_ACTIVE;
          end
        end
        led_pwm_pkg::OD_ACTIVE: begin
          if (!odet_r[`ODET_EN_BIT]) begin
            // Last status is held once disabled
            od_state_r <= led_pwm_pkg::OD_IDLE;
          end else begin
            // Sample only channels being driven
            open_r <= open_sense & led_sink_channel;
          end
        end
        default: begin
          od_state_r <= led_pwm_pkg::OD_IDLE;
        end
      endcase
    end
  end

  // Interrupt pin low while any open is reported
  always_ff @(posedge clock) begin
    if (clear) begin
      fault_irq_n <= 1'b1;
    end else begin
      fault_irq_n <= ~(odet_r[`ODET_REPORT_BIT] & (|open_r));
    end
  end

  // ****************************************
  // Register read
  // ****************************************
  always_ff @(posedge clock) begin
    if (clear) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        // Unmapped and write-only offsets read zero
        reg_rdata <= 8'h00;
        if (reg_addr == `A_CTRL) begin
          reg_rdata <= ctrl_r;
        end
        if (reg_addr == `A_GCC) begin
          reg_rdata <= gcc_r;
        end
        if (reg_addr == `A_ODET) begin
          reg_rdata <= odet_r;
        end
        if (reg_addr == `A_BPER) begin
          reg_rdata <= bper_stage_r;
        end
        if (reg_addr == `A_BDUTY) begin
          reg_rdata <= bduty_stage_r;
        end
        for (int i = 0; i < CH; i++) begin
          if (reg_addr == `A_SCALE_FIRST + 8'(i)) begin
            reg_rdata <= scale_stage_r[i];
          end
          if (reg_addr == `A_PWM_FIRST + 8'(i)) begin
            reg_rdata <= pwm_stage_r[i];
          end
        end
        // Grouped bit registers, six channels per byte
        for (int k = 0; k < CH / 6; k++) begin
          if (reg_addr == `A_DC_FIRST + 8'(k)) begin
            reg_rdata <= {1'b0, dc_r[k*6+3 +: 3], 1'b0, dc_r[k*6 +: 3]};
          end
          if (reg_addr == `A_BSEL_FIRST + 8'(k)) begin
            reg_rdata <= {1'b0, bsel_stage_r[k*6+3 +: 3],
                          1'b0, bsel_stage_r[k*6 +: 3]};
          end
          if (reg_addr == `A_OPEN_FIRST + 8'(k)) begin
            reg_rdata <= {1'b0, open_r[k*6+3 +: 3], 1'b0, open_r[k*6 +: 3]};
          end
        end
      end
    end
  end

endmodule : led_pwm_blink_update_control

// ### bench/led_pwm_sva.sv
`timescale 1ns/10ps
// ****************************************
// Port checker
// ****************************************
module led_pwm_sva #(
  parameter int CH = 18
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rvalid,
  // Sink and fault side
  input wire logic [CH-1:0] led_sink_channel,
  input wire logic [CH*8-1:0] active_scale_flat,
  input wire logic [7:0] global_current_code,
  input wire logic current_range_eighth,
  input wire logic fault_irq_n
);
  // Decoded writes
  logic w_ctl, w_srst, w_bad, w_sup;
  assign w_ctl = reg_wr && reg_addr == 8'h00;
  assign w_srst = reg_wr && reg_addr == 8'h3F && reg_wdata == 8'hAE;
  assign w_bad = reg_wr && reg_addr == 8'h3F && reg_wdata != 8'hAE;
  assign w_sup = reg_wr && reg_addr == 8'h36 && reg_wdata == 8'h00;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // Run bit dropped, then two quiet control cycles
  sequence s_run_off;
    w_ctl && !reg_wdata[0] ##1 !w_ctl [*2];
  endsequence
  // Wrong key, then an idle cycle
  sequence s_bad_key;
    w_bad ##1 !reg_wr;
  endsequence
  sequence s_srst;
    w_srst ##1 !reg_wr;
  endsequence
  property p_srst;
    s_srst |=> global_current_code == 8'h00 && !current_range_eighth
      && led_sink_channel == '0 && active_scale_flat == '0 && fault_irq_n;
  endproperty
  a_srst: assert property (p_srst) else $error("soft reset missed");
  property p_bad_key;
    s_bad_key |=> $stable(global_current_code);
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("bad key acted");
  property p_rst;
    $rose(rstn) |-> led_sink_channel == '0 && fault_irq_n
      && global_current_code == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_run_off;
    s_run_off |=> led_sink_channel == '0;
  endproperty
  a_run_off: assert property (p_run_off) else $error("sink while off");
  property p_range;
    w_ctl && !$past(w_srst) |=> current_range_eighth == $past(reg_wdata[5]);
  endproperty
  a_range: assert property (p_range) else $error("range bit wrong");
  property p_scale_hold;
    !w_sup && !w_srst |=> $stable(active_scale_flat);
  endproperty
  a_scale_hold: assert property (p_scale_hold) else $error("scale moved");
  property p_gcc;
    reg_wr && reg_addr == 8'h01 && !$past(w_srst)
      |=> global_current_code == $past(reg_wdata);
  endproperty
  a_gcc: assert property (p_gcc) else $error("global code wrong");
  property p_rd;
    1'b1 |=> reg_rvalid == $past(reg_rd);
  endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
endmodule : led_pwm_sva

bind led_pwm_blink_update_control led_pwm_sva #(.CH(CH)) u_led_pwm_sva (
  .clock(clock), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rvalid(reg_rvalid),
  .led_sink_channel(led_sink_channel),
  .active_scale_flat(active_scale_flat),
  .global_current_code(global_current_code),
  .current_range_eighth(current_range_eighth),
  .fault_irq_n(fault_irq_n)
);

// ### bench/host_model.sv
`timescale 1ns/10ps
// ****************************************
// Host register master
// ****************************************
module host_model (
  // Clock
  input wire logic clock,
  // Register port drive
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  // Idle port from time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // One strobe cycle, launched and dropped on falling edges
  task automatic go(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clock);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    // Idle lines carry junk, never the last value
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : go
  // Update triggers only ever carry the zero key
  task automatic upd(input logic [7:0] a);
    go(1'b1, a, 8'h00);
  endtask : upd
endmodule : host_model

// ### bench/led_pwm_blink_update_control_tb_top.sv
`timescale 1ns/10ps
// Compare one value, count it, report a miss
`define CHK(a, e) begin \
  n_checks++; \
  if ((a) !== (e)) begin \
    fails++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); \
  end \
end
// ****************************************
// Bench top
// ****************************************
module led_pwm_blink_update_control_tb_top;
  // Shortened divider counts
  localparam int SDIV = 4;
  localparam int FDIV = 2;
  localparam int BDIV = 4;
  // Design ports
  logic clock, rstn, reg_wr, reg_rd, reg_rvalid, current_range_eighth;
  logic fault_irq_n;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, global_current_code;
  logic [17:0] open_sense, led_sink_channel;
  logic [143:0] active_scale_flat;
  // Bench state
  int fails = 0;
  int n_checks = 0;
  int seed = 32'h0125;
  int c0, c1, skew, lr;
  logic [7:0] q[$];
  logic [7:0] sv, d, e;
  led_pwm_blink_update_control #(.PWM_SLOW_DIV(SDIV), .PWM_FAST_DIV(FDIV),
    .BLINK_TICK_DIV(BDIV)) u_led_pwm_blink_update_control (
    .clock(clock), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .open_sense(open_sense),
    .led_sink_channel(led_sink_channel),
    .active_scale_flat(active_scale_flat),
    .global_current_code(global_current_code),
    .current_range_eighth(current_range_eighth), .fault_irq_n(fault_irq_n));
  host_model u_host_model (.clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  // 50 ns clock
  initial clock = 1'b0;
  always #25 clock = ~clock;
  // Read answers against the oldest note
  always @(negedge clock) begin
    if (reg_rvalid === 1'b1) begin
      e = q.pop_front();
      `CHK(reg_rdata, e)
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    u_host_model.go(1'b1, a, x);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    q.push_back(x);
    u_host_model.go(1'b0, a, 8'h00);
  endtask : rd
  // On-cycles of sinks 0 and 1, split rises, longest run of sink 0
  task automatic meas(input int n);
    logic [1:0] p, r;
    int run;
    c0 = 0;
    c1 = 0;
    skew = 0;
    lr = 0;
    run = 0;
    // Skip the edge still driven by the old settings
    @(negedge clock);
    p = led_sink_channel[1:0];
    repeat (n) begin
      @(negedge clock);
      r = led_sink_channel[1:0] & ~p;
      p = led_sink_channel[1:0];
      c0 += p[0];
      c1 += p[1];
      skew += r[0] ^ r[1];
      run = p[0] ? run + 1 : 0;
      if (run > lr) lr = run;
    end
  endtask : meas
  task conclude;
    $display("checks=%0d mismatches=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude
  // Watchdog
  initial begin
    #(50 * 80000);
    fails++;
    conclude();
  end
  // Main sequence
  initial begin
    rstn = 1'b0;
    open_sense = '0;
    repeat (4) @(negedge clock);
    rstn = 1'b1;
    rd(8'h34, 8'h00);
    rd(8'h50, 8'h00);
    rd(8'h37, 8'h00);
    // Scaling staged until zero key at 36h
    sv = 8'($random(seed));
    wr(8'h02, sv);
    wr(8'h13, ~sv);
    wr(8'h36, 8'h01);
    `CHK(active_scale_flat, 144'h0)
    rd(8'h02, sv);
    u_host_model.upd(8'h36);
    `CHK(active_scale_flat[7:0], sv)
    `CHK(active_scale_flat[143:136], ~sv)
    wr(8'h01, 8'h20);
    wr(8'h00, 8'h21);
    `CHK(current_range_eighth, 1'b1)
    // Slow PWM, staged duty first
    d = 8'($random(seed)) | 8'h01;
    wr(8'h1F, d);
    wr(8'h20, 8'h08);
    meas(256 * SDIV);
    `CHK(c0, 0)
    u_host_model.upd(8'h37);
    meas(256 * SDIV);
    `CHK(c0, d * SDIV)
    `CHK(c1, 8 * SDIV)
    `CHK(skew, 0)
    wr(8'h00, 8'h23);
    repeat (600) @(negedge clock);
    meas(256 * FDIV);
    `CHK(c0, d * FDIV)
    wr(8'h00, 8'h22);
    meas(512);
    `CHK(c0 + c1, 0)
    wr(8'h00, 8'h01);
    wr(8'h1A, 8'h01);
    meas(256 * SDIV);
    `CHK(c0, 256 * SDIV)
    // Blink staged, then period code 1 and half duty
    wr(8'h31, 8'h01);
    wr(8'h34, 8'h01);
    wr(8'h35, 8'h80);
    meas(1024);
    `CHK(c0, 1024)
    u_host_model.upd(8'h37);
    repeat (2100) @(negedge clock);
    meas(8 * 256 * BDIV);
    `CHK(c0, 4 * 256 * BDIV)
    `CHK(lr, 128 * 2 * BDIV)
    // Open detect with sink 0 held on
    wr(8'h31, 8'h00);
    u_host_model.upd(8'h37);
    open_sense = 18'h00001;
    wr(8'h14, 8'h03);
    repeat (4) @(negedge clock);
    `CHK(fault_irq_n, 1'b0)
    rd(8'h95, 8'h01);
    wr(8'h14, 8'h01);
    repeat (2) @(negedge clock);
    `CHK(fault_irq_n, 1'b1)
    open_sense = 18'h00000;
    repeat (3) @(negedge clock);
    rd(8'h95, 8'h00);
    wr(8'h14, 8'h00);
    open_sense = 18'h00001;
    repeat (3) @(negedge clock);
    rd(8'h95, 8'h00);
    // Second DC group: D6:D4 and D2:D0 map to channels 6 to 11
    wr(8'h1B, 8'hFF);
    rd(8'h1B, 8'h77);
    `CHK(led_sink_channel[11:6], 6'h3F)
    // Soft reset, wrong key first
    wr(8'h3F, 8'h12);
    `CHK(global_current_code, 8'h20)
    wr(8'h3F, 8'hAE);
    @(negedge clock);
    `CHK(global_current_code, 8'h00)
    `CHK(active_scale_flat, 144'h0)
    `CHK(led_sink_channel, 18'h0)
    rd(8'h1F, 8'h00);
    repeat (3) @(negedge clock);
    conclude();
  end
endmodule : led_pwm_blink_update_control_tb_top
